// *** hdl/mrs_pkg.sv ***
// Purpose: Constants, types and register map of the reset sequencer.
// Assumes: One 200 MHz system clock, 32-bit AHB-Lite register bus.
// Notes:   Byte offsets are word aligned.
package mrs_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS   = 5;
   localparam int unsigned STARTUP_CYCLES  = 1024;
   localparam int unsigned OPTLOAD_CYCLES  = 16;
   localparam logic [10:0] STARTUP_LAST    = 11'h3ff;
   localparam logic [10:0] OPTLOAD_LAST    = 11'h00f;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ_ST = 8'h08;
   localparam logic [7:0] OFS_IRQ_MK = 8'h0c;
   localparam logic [7:0] OFS_CAUSE  = 8'h10;

   // ----------------------------------------------------------------
   // Reset values loaded on a full reset
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_WDT_SEL  = 8'h07;
   localparam logic [7:0] RST_TMR_CTL  = 8'h08;
   localparam logic [7:0] RST_PORT     = 8'hff;
   localparam logic [2:0] RST_PORT_C   = 3'h7;
   localparam logic [7:0] RST_BANK     = 8'h00;
   localparam logic [7:0] RST_INT_CTL  = 8'h00;
   localparam logic [3:0] RST_EE_CTL   = 4'h8;
   localparam logic [9:0] RST_PC       = 10'h000;
   localparam logic [1:0] RST_SP       = 2'h0;

   // ----------------------------------------------------------------
   // Interrupt event bits
   // ----------------------------------------------------------------
   localparam int unsigned EV_FULL = 0;
   localparam int unsigned EV_WARM = 1;
   localparam int unsigned EV_RUN  = 2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0]
   {
      MRS_RESET   = 4'b0001,
      MRS_OPTLOAD = 4'b0010,
      MRS_STARTUP = 4'b0100,
      MRS_RUN     = 4'b1000
   } mrs_state_e;

   typedef struct packed
   {
      logic [7:0] wdt_sel;
      logic [7:0] tmr_ctl;
      logic [7:0] port_a;
      logic [7:0] port_a_dir;
      logic [7:0] port_b;
      logic [7:0] port_b_dir;
      logic [2:0] port_c;
      logic [2:0] port_c_dir;
      logic [7:0] bank;
      logic [7:0] int_ctl;
      logic [3:0] ee_ctl;
   } mrs_regs_s;

   typedef struct packed
   {
      logic       load_regs;
      logic       load_pc_sp;
      logic       wdt_clear;
      logic       table_high_byte_unknown;
   } mrs_load_s;

endpackage

// *** hdl/mrs_seq.sv ***
// Purpose: Reset cause capture and start-up sequencing for the core.
// Assumes: Watchdog, halt logic and core sit outside; strobes are
//          synchronous one-cycle pulses except the reset pin level.
// Notes:   All state is one packed struct, registered in one place.
// Function
// - Three reset causes: pin run, pin halt, watchdog.
// - Watchdog in halt resets only PC, SP.
// - Cause flags follow the cause table.
// - Start-up timer holds 1024 clocks.
// - Start-up delay lies inside reset period.
// - Every halt wake-up runs start-up delay.
// - Full resets add option-load delay first.
// - Chip reset loads PC, SP, ports, timer off.
// - Warm reset keeps registers; others reload.
// - Full reset loads documented register values.
// - Pointers, accumulator kept; table high bits unknown.
// - Low reset pin clears watchdog and prescaler.
// - Powerdown flag: clear power-up/clear-wdt, set halt.
//
// Decided for this implementation: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
module mrs_seq
   import mrs_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        external_reset_pin,
   input  wire logic        watchdog_timeout,
   input  wire logic        halt_exec,
   input  wire logic        clr_wdt_exec,
   input  wire logic        wake_event,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             core_run,
   output logic             watchdog_timeout_flag,
   output logic             powerdown_flag,
   output mrs_regs_s        regs,
   output mrs_load_s        load,
   output logic [9:0]       pc_value,
   output logic [1:0]       sp_value,
   output logic             irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic        pin_s1;
      logic        pin_s2;
      logic        pin_d;
      mrs_state_e  st;
      logic [10:0] startup_timer;
      logic        halted;
      logic        to_f;
      logic        pd_f;
      mrs_regs_s   regs;
      mrs_load_s   load;
      logic        run;
      logic [2:0]  irq_st;
      logic [2:0]  irq_mk;
      logic [1:0]  cause;
      logic        hold_run;
      logic        ap_wr;
      logic [7:0]  ap_addr;
      logic [31:0] rdata;
      logic        irq;
   } mrs_state_s;

   mrs_state_s s;
   mrs_state_s next_s;

   function automatic logic [31:0] mrs_zext8(input logic [7:0] v);
      mrs_zext8 = {24'h00_0000, v};
   endfunction

   // First timer value of the option-load or start-up stage.
   function automatic logic [10:0] mrs_first(input logic with_opt);
      mrs_first = with_opt ? OPTLOAD_LAST : STARTUP_LAST;
   endfunction

   logic pin_low;
   logic halt_wdt;
   logic run_wdt;
   logic warm;
   logic full;
   logic rd_take;
   logic [31:0] rd_mux;

   // ----------------------------------------------------------------
   // Cause decode
   // ----------------------------------------------------------------
   // The pin is sampled only after the second stage; the first stage
   // feeds nothing else so that metastability cannot leak.
   always_comb
   begin
      pin_low  = !s.pin_s2;
      run_wdt  = watchdog_timeout && !s.halted &&
                 s.st == MRS_RUN;
      halt_wdt = watchdog_timeout && s.halted;
      full     = (pin_low && !s.pin_d) || run_wdt;
      warm     = halt_wdt && !full;
      rd_take  = hsel && hready && htrans[1] && !hwrite;
   end

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   // Decoded in the address phase. A read right behind a write to the
   // same register still returns the old value; keep an idle between.
   always_comb
   begin
      unique case (haddr[7:0])
         OFS_CTRL:   rd_mux = {31'h000_0000, s.hold_run};
         OFS_STATUS: rd_mux = {27'h000_0000, s.st, s.run};
         OFS_IRQ_ST: rd_mux = {29'h000_0000, s.irq_st};
         OFS_IRQ_MK: rd_mux = {29'h000_0000, s.irq_mk};
         OFS_CAUSE:  rd_mux = mrs_zext8({6'h00, s.cause});
         default:    rd_mux = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_s        = s;
      next_s.pin_s1 = external_reset_pin;
      next_s.pin_s2 = s.pin_s1;
      next_s.pin_d  = pin_low;
      next_s.load   = '0;
      next_s.load.wdt_clear = pin_low || halt_exec ||
                              clr_wdt_exec;

      // Bus read: data is registered in the address phase so that it
      // stands through the data phase. A status read clears the bits
      // here, before the sequencer below, so a new event still wins.
      if (rd_take)
      begin
         next_s.rdata = rd_mux;
         if (haddr[7:0] == OFS_IRQ_ST)
         begin
            next_s.irq_st = 3'h0;
         end
      end

      // Powerdown flag, then cause flags which override it.
      if (halt_exec)
      begin
         next_s.pd_f = 1'b1;
         next_s.to_f = 1'b0;
      end
      else if (clr_wdt_exec)
      begin
         next_s.pd_f = 1'b0;
      end
      if (halt_exec)
      begin
         next_s.halted = 1'b1;
      end

      // Sequencer.
      unique case (s.st)
         MRS_RESET:
         begin
            next_s.run = 1'b0;
            if (!pin_low)
            begin
               next_s.st = MRS_OPTLOAD;
               next_s.startup_timer = mrs_first(1'b1);
            end
         end
         MRS_OPTLOAD:
         begin
            next_s.run = 1'b0;
            next_s.startup_timer = s.startup_timer - 11'h001;
            if (s.startup_timer == 11'h000)
            begin
               next_s.st = MRS_STARTUP;
               next_s.startup_timer = STARTUP_LAST;
            end
         end
         MRS_STARTUP:
         begin
            next_s.run = 1'b0;
            next_s.startup_timer = s.startup_timer - 11'h001;
            if (s.startup_timer == 11'h000)
            begin
               next_s.st = MRS_RUN;
               next_s.run = !s.hold_run;
               next_s.irq_st[EV_RUN] = 1'b1;
               next_s.halted = 1'b0;
            end
         end
         MRS_RUN:
         begin
            next_s.run = !s.hold_run && !s.halted && !halt_exec;
            if (s.halted && wake_event && !halt_wdt && !pin_low)
            begin
               next_s.st = MRS_STARTUP;
               next_s.startup_timer = STARTUP_LAST;
               next_s.run = 1'b0;
            end
         end
      endcase

      // Warm reset: only program counter and stack pointer.
      if (warm)
      begin
         next_s.load.load_pc_sp   = 1'b1;
         next_s.load.table_high_byte_unknown = 1'b1;
         next_s.to_f = 1'b1;
         next_s.pd_f = 1'b1;
         next_s.cause = 2'h3;
         next_s.st = MRS_STARTUP;
         next_s.startup_timer = STARTUP_LAST;
         next_s.run = 1'b0;
         next_s.irq_st[EV_WARM] = 1'b1;
      end

      // Full reset: registers reload, pointers and accumulator kept.
      if (full)
      begin
         next_s.load.load_regs    = 1'b1;
         next_s.load.load_pc_sp   = 1'b1;
         next_s.load.table_high_byte_unknown = 1'b1;
         next_s.regs.wdt_sel    = RST_WDT_SEL;
         next_s.regs.tmr_ctl    = RST_TMR_CTL;
         next_s.regs.port_a     = RST_PORT;
         next_s.regs.port_a_dir = RST_PORT;
         next_s.regs.port_b     = RST_PORT;
         next_s.regs.port_b_dir = RST_PORT;
         next_s.regs.port_c     = RST_PORT_C;
         next_s.regs.port_c_dir = RST_PORT_C;
         next_s.regs.bank       = RST_BANK;
         next_s.regs.int_ctl    = RST_INT_CTL;
         next_s.regs.ee_ctl     = RST_EE_CTL;
         if (run_wdt)
         begin
            next_s.to_f  = 1'b1;
            next_s.cause = 2'h2;
         end
         else if (s.halted)
         begin
            next_s.to_f  = 1'b0;
            next_s.pd_f  = 1'b1;
            next_s.cause = 2'h1;
         end
         else
         begin
            next_s.cause = 2'h0;
         end
         next_s.halted = 1'b0;
         next_s.run    = 1'b0;
         next_s.st     = pin_low ? MRS_RESET : MRS_OPTLOAD;
         next_s.startup_timer = mrs_first(1'b1);
         next_s.irq_st[EV_FULL] = 1'b1;
      end

      // Bus write: the data word stands in the data phase.
      if (s.ap_wr)
      begin
         if (s.ap_addr == OFS_CTRL)
         begin
            next_s.hold_run = hwdata[0];
         end
         if (s.ap_addr == OFS_IRQ_MK)
         begin
            next_s.irq_mk = hwdata[2:0];
         end
      end
      next_s.ap_wr   = hsel && hready && htrans[1] && hwrite;
      next_s.ap_addr = haddr[7:0];
      next_s.irq     = |(next_s.irq_st & next_s.irq_mk);
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Power-up clears both flags and the cause and loads the register reset values;
   // afterwards the cause is only reloaded when a pin or watchdog reset occurs.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s       <= '0;
         s.st    <= MRS_RESET;
         s.pin_d  <= 1'b1;
         s.regs  <= '{RST_WDT_SEL, RST_TMR_CTL, RST_PORT, RST_PORT,
                      RST_PORT, RST_PORT, RST_PORT_C, RST_PORT_C,
                      RST_BANK, RST_INT_CTL, RST_EE_CTL};
         s.load  <= '{1'b1, 1'b1, 1'b1, 1'b1};
      end
      else
      begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Every output except hreadyout, hresp, pc_value and sp_value is a field of the state register.
   assign hrdata    = s.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign core_run  = s.run;
   assign watchdog_timeout_flag = s.to_f;
   assign powerdown_flag = s.pd_f;
   assign regs      = s.regs;
   assign load      = s.load;
   assign pc_value  = RST_PC;
   assign sp_value  = RST_SP;
   assign irq       = s.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_run_after_delay: assert property (@(posedge hclk) disable iff
      (!hresetn) $rose(s.run) |-> $past(s.st) != MRS_OPTLOAD)
      else $error("core released during option load");
   a_startup_len: assert property (@(posedge hclk) disable iff
      (!hresetn) (s.st == MRS_STARTUP && s.startup_timer == STARTUP_LAST
      && !full && !warm) |-> (s.st != MRS_RUN) [*8])
      else $error("start-up delay ended early");
   a_full_loads: assert property (@(posedge hclk) disable iff
      (!hresetn) full |=> s.load.load_regs && s.load.load_pc_sp
      && s.regs.wdt_sel == RST_WDT_SEL)
      else $error("full reset did not load values");
   a_warm_keeps: assert property (@(posedge hclk) disable iff
      (!hresetn) warm |=> !s.load.load_regs && s.load.load_pc_sp
      && $stable(s.regs))
      else $error("warm reset disturbed registers");
   a_warm_flags: assert property (@(posedge hclk) disable iff
      (!hresetn) warm |=> s.to_f && s.pd_f)
      else $error("warm reset flags wrong");
   a_pin_flags: assert property (@(posedge hclk) disable iff
      (!hresetn) (full && !run_wdt && s.halted) |=> !s.to_f && s.pd_f)
      else $error("halt pin reset flags wrong");
   a_wdt_flag: assert property (@(posedge hclk) disable iff
      (!hresetn) (run_wdt && !pin_low) |=> s.to_f && s.st == MRS_OPTLOAD)
      else $error("watchdog reset flag or delay wrong");
   a_halt_pd: assert property (@(posedge hclk) disable iff
      (!hresetn) (halt_exec && !full && !warm) |=> s.pd_f && !s.to_f)
      else $error("halt did not set powerdown flag");
   a_pin_wdtclr: assert property (@(posedge hclk) disable iff
      (!hresetn) pin_low |=> s.load.wdt_clear)
      else $error("low pin did not clear watchdog");
   a_wake_delay: assert property (@(posedge hclk) disable iff
      (!hresetn) (s.st == MRS_RUN && s.halted && wake_event && !full
      && !warm && !pin_low) |=> s.st == MRS_STARTUP && !s.run)
      else $error("wake-up skipped start-up delay");

endmodule

// *** hdl/unused_placeholder_removed.sv ***
// Purpose: Holds no logic; the whole sequencer lives in mrs_seq.
// Assumes: Nothing is taken from this file but the time unit.
// Notes:   Kept empty on purpose.
`timescale 1ns/10ps

// *** sim/mrs_board_reset.sv ***
// Purpose: Board reset circuit that drives the external reset pin.
// Assumes: The pin has a pull-up, so it reads high when not pressed.
// Notes:   A one-cycle press holds the pin low for LOW_CYCLES clocks.
`timescale 1ns/10ps
module mrs_board_reset
#(
   parameter int LOW_CYCLES = 8
)
(
   input  wire logic hclk,
   input  wire logic press,
   output logic      external_reset_pin
);
   // ----------------------------------------------------------------
   // Press stretcher
   // ----------------------------------------------------------------
   int cnt = 0;

   // A press loads the low time; the count runs down once per clock.
   always @(posedge hclk)
   begin
      if (press)
         cnt <= LOW_CYCLES;
      else if (cnt > 0)
         cnt <= cnt - 1;
   end

   // The pull-up returns the pin high once the count has run down to zero.
   always_comb external_reset_pin = (cnt == 0);
endmodule

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for the reset sequencer.
// Assumes: A mask bit set to one enables that interrupt event.
// Notes:   Delay checks allow a few cycles for synchronisers.
`timescale 1ns/10ps
module tb_top
   import mrs_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam logic [73:0] REGS_FULL = {8'h07, 8'h08, 8'hff, 8'hff,
      8'hff, 8'hff, 3'h7, 3'h7, 8'h00, 8'h00, 4'h8};
   localparam int          LOW = 8;
   localparam int          FULL = OPTLOAD_CYCLES + STARTUP_CYCLES;
   logic                   hclk;
   logic                   hresetn;
   logic                   external_reset_pin;
   logic                   watchdog_timeout;
   logic                   halt_exec;
   logic                   clr_wdt_exec;
   logic                   wake_event;
   logic                   press;
   logic                   hsel;
   logic                   hwrite;
   logic [31:0]            haddr;
   logic [31:0]            hwdata;
   logic [31:0]            hrdata;
   logic [31:0]            rd;
   logic [1:0]             htrans;
   logic [2:0]             hsize;
   logic                   hreadyout;
   logic                   hresp;
   logic                   core_run;
   logic                   watchdog_timeout_flag;
   logic                   powerdown_flag;
   mrs_regs_s              regs;
   mrs_load_s              load;
   logic [9:0]             pc_value;
   logic [1:0]             sp_value;
   logic                   irq;
   int                     n_fail = 0;
   int                     checked = 0;
   int                     n_lr;
   int                     n_ps;
   int                     n_wc;

   mrs_board_reset #(.LOW_CYCLES(LOW)) i_board (.hclk(hclk), .press(press),
      .external_reset_pin(external_reset_pin));

   mrs_seq i_dut (.hclk(hclk), .hresetn(hresetn),
      .external_reset_pin(external_reset_pin),
      .watchdog_timeout(watchdog_timeout), .halt_exec(halt_exec),
      .clr_wdt_exec(clr_wdt_exec), .wake_event(wake_event), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .core_run(core_run),
      .watchdog_timeout_flag(watchdog_timeout_flag),
      .powerdown_flag(powerdown_flag), .regs(regs), .load(load),
      .pc_value(pc_value), .sp_value(sp_value), .irq(irq));

   // ----------------------------------------------------------------
   // Clock, load pulse monitor and hang guard
   // ----------------------------------------------------------------
   // The clock toggles every half period of 2.5 ns.
   initial
   begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   // Load strobes are one cycle wide, except wdt_clear while the pin is low, so they are counted, not sampled.
   always @(posedge hclk)
   begin
      n_lr += int'(load.load_regs === 1'b1);
      n_ps += int'(load.load_pc_sp === 1'b1 && load.table_high_byte_unknown === 1'b1);
      n_wc += int'(load.wdt_clear === 1'b1);
   end

   // The whole sequence needs about 6400 cycles; 40000 means a hang.
   initial
   begin
      #200_000;
      n_fail++;
      tally_and_finish();
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [79:0] seen,
                      input logic [79:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   // One single-word transfer; read data is taken at the data edge.
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask

   // A one-cycle strobe on the selected event input.
   task automatic pulse(input int k);
      @(posedge hclk);
      case (k)
         0: watchdog_timeout <= 1'b1;
         1: halt_exec <= 1'b1;
         2: clr_wdt_exec <= 1'b1;
         3: wake_event <= 1'b1;
         default: press <= 1'b1;
      endcase
      @(posedge hclk);
      {watchdog_timeout, halt_exec, clr_wdt_exec, wake_event, press} <= '0;
   endtask

   // Counts edges until core_run reaches lvl and checks the span.
   task automatic wait_core(input logic lvl, input int lo, input int hi,
                            input string nm);
      int cnt;
      cnt = 0;
      while (core_run !== lvl && cnt < 3000)
      begin
         @(posedge hclk);
         cnt++;
      end
      chk(nm, {79'h0, (cnt >= lo && cnt <= hi)}, 80'h1);
   endtask

   task automatic flags(input logic [1:0] exp);
      repeat (2) @(posedge hclk);
      chk("flags", {watchdog_timeout_flag, powerdown_flag}, exp);
   endtask

   task automatic tally_and_finish();
      if (n_fail == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial
   begin
      {hresetn, watchdog_timeout, halt_exec, clr_wdt_exec} = '0;
      {wake_event, press, hsel, hwrite} = '0;
      {haddr, hwdata} = '0;
      htrans = 2'b00;
      hsize = 3'h2;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      // Power-up: option load and start-up both precede execution.
      wait_core(1'b1, FULL, FULL + 8, "powerup span");
      flags(2'b00);
      chk("regs", regs, REGS_FULL);
      chk("pc sp", {pc_value, sp_value}, 12'h000);
      ahb(1'b1, OFS_IRQ_MK, 32'h0000_0007, rd);
      @(posedge hclk); // The interrupt is registered after the mask write.
      chk("irq run", irq, 1'b1);
      ahb(1'b0, OFS_IRQ_ST, 32'h0000_0000, rd);
      chk("irq st", rd[2], 1'b1);
      ahb(1'b0, OFS_IRQ_ST, 32'h0000_0000, rd);
      chk("irq clr", {rd, irq, hresp}, 34'h0);
      ahb(1'b0, OFS_STATUS, 32'h0000_0000, rd);
      chk("status", rd[4:0], {MRS_RUN, 1'b1});
      ahb(1'b0, 8'h20, 32'h0000_0000, rd);
      chk("unmapped", rd, 32'h0000_0000);
      // Hold bit stops the core and releases it again.
      ahb(1'b1, OFS_CTRL, 32'h0000_0001, rd);
      wait_core(1'b0, 0, 4, "hold stop");
      ahb(1'b0, OFS_CTRL, 32'h0000_0000, rd);
      chk("ctrl", rd[0], 1'b1);
      ahb(1'b1, OFS_CTRL, 32'h0000_0000, rd);
      wait_core(1'b1, 0, 1100, "hold free");
      ahb(1'b1, OFS_IRQ_MK, 32'h0000_0002, rd);
      // Reset pin while halted; the halt's own clear is not counted.
      pulse(1);
      flags(2'b01);
      {n_lr, n_ps, n_wc} = '0;
      pulse(4);
      repeat (LOW + 1) @(posedge hclk);
      wait_core(1'b1, FULL, FULL + 8, "pin halt span");
      flags(2'b01);
      chk("pin halt", {n_lr > 0, n_ps > 0, n_wc > 0}, 3'h7);
      ahb(1'b0, OFS_CAUSE, 32'h0000_0000, rd);
      chk("cause", rd, 32'h0000_0001);
      chk("irq masked", irq, 1'b0);
      ahb(1'b0, OFS_IRQ_ST, 32'h0000_0000, rd);
      chk("irq st", rd[2:0], 3'h5);
      // Reset pin while running leaves the flags as they were.
      {n_lr, n_wc} = '0;
      pulse(4);
      repeat (LOW + 1) @(posedge hclk);
      wait_core(1'b1, FULL, FULL + 8, "pin run span");
      flags(2'b01);
      chk("pin run", {n_lr > 0, n_wc > 0}, 2'h3);
      ahb(1'b0, OFS_CAUSE, 32'h0000_0000, rd);
      chk("cause", rd, 32'h0000_0000);
      // Watchdog while halted gives a warm reset.
      {n_lr, n_ps} = '0;
      pulse(1);
      pulse(0);
      wait_core(1'b1, STARTUP_CYCLES - 2, STARTUP_CYCLES + 8, "warm");
      flags(2'b11);
      chk("warm", {n_lr, n_ps > 0}, 33'h1);
      chk("irq warm", irq, 1'b1);
      ahb(1'b0, OFS_CAUSE, 32'h0000_0000, rd);
      chk("cause", rd, 32'h0000_0003);
      ahb(1'b0, OFS_IRQ_ST, 32'h0000_0000, rd);
      chk("irq st", {rd[1], irq}, 2'b10);
      // Watchdog while running gives a full reset.
      n_lr = 0;
      pulse(0);
      wait_core(1'b0, 0, 8, "wdt stop");
      wait_core(1'b1, FULL - 8, FULL + 8, "wdt span");
      flags(2'b11);
      chk("wdt load", {n_lr > 0, regs}, {1'b1, REGS_FULL});
      ahb(1'b0, OFS_CAUSE, 32'h0000_0000, rd);
      chk("cause", rd, 32'h0000_0002);
      pulse(2);
      flags(2'b10);
      // Wake-up from halt runs only the start-up delay.
      n_lr = 0;
      pulse(1);
      wait_core(1'b0, 0, 4, "halt stop");
      pulse(3);
      wait_core(1'b1, STARTUP_CYCLES - 2, STARTUP_CYCLES + 8, "wake");
      flags(2'b01);
      chk("wake load", n_lr, 80'h0);
      tally_and_finish();
   end
endmodule
